// *** shared/irq_ctrl_pkg.sv ***
// Contract
// - Six sources, each with its own pending flag, mask bit and vector.
// - One global enable gates all servicing; zero means nothing is serviced.
// - Control bits sit at locations 000 to 003, reachable by bit instructions.
// - Software can only clear pending flags; only hardware events set them.
// - Reset clears global enable and pending flags, sets all masks.
// - Request is pending and unmasked; serviced only with global enable high.
// - Fixed priority ext0, ext1, timers A, B, C, serial; vectors 2 to C.
// - Entry: finish instruction, clear enable, push flags and PC, jump.
// - Global enable at 000 bit 0; cleared by entry, set by return.
// - With ext1 as timer B clock, each falling edge advances timer B.
// - Ext0 falling edge sets 000 bit 2; ext1 sets 001 bit 0.
// - Ext masks at 000 bit 3 and 001 bit 1; one blocks.
// - Timer A pending at 001 bit 2, mask at bit 3.
// - Timer B pending at 002 bit 0, mask at bit 1.
// - Timer C pending at 002 bit 2, mask at bit 3.
// - Serial pending at 003 bit 0 on eighth shift or abort; mask bit 1.
`default_nettype none
package irq_ctrl_pkg;

   // ---------------------------------------------------------------
   // Sizes and locations
   // ---------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int NUM_SRC = 6;
   localparam logic [9:0] LOC_CTRL_0 = 10'h000;
   localparam logic [9:0] LOC_CTRL_3 = 10'h003;

   // ---------------------------------------------------------------
   // Source indices, in priority order
   // ---------------------------------------------------------------
   localparam int SRC_EXT0 = 0;
   localparam int SRC_EXT1 = 1;
   localparam int SRC_TIMER_A = 2;
   localparam int SRC_TIMER_B = 3;
   localparam int SRC_TIMER_C = 4;
   localparam int SRC_SERIAL = 5;

   // ---------------------------------------------------------------
   // Field layout: location and bit of each flag
   // ---------------------------------------------------------------
   localparam logic [1:0] IE_LOC = 2'h0;
   localparam logic [1:0] IE_BIT = 2'h0;
   localparam logic [NUM_SRC-1:0][1:0] SRC_LOC = {2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
   localparam logic [NUM_SRC-1:0][1:0] PEND_BIT = {2'h0, 2'h2, 2'h0, 2'h2, 2'h0, 2'h2};
   localparam logic [NUM_SRC-1:0][1:0] MASK_BIT = {2'h1, 2'h3, 2'h1, 2'h3, 2'h1, 2'h3};

   // ---------------------------------------------------------------
   // Vectors
   // ---------------------------------------------------------------
   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [NUM_SRC-1:0][15:0] VEC_TABLE = {
      16'h000C, 16'h000A, 16'h0008, 16'h0006, 16'h0004, 16'h0002};

   // ---------------------------------------------------------------
   // Reset values and timing
   // ---------------------------------------------------------------
   localparam logic IE_RESET = 1'b0;
   localparam logic [NUM_SRC-1:0] PEND_RESET = 6'h00;
   localparam logic [NUM_SRC-1:0] MASK_RESET = 6'h3F;
   localparam int EXT_HOLD_CYCLES = 2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FINISH,
      ST_CLEAR_PUSH,
      ST_PUSH_JUMP
   } entry_state_type;

endpackage
`default_nettype wire

// *** rtl/ext_edge_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_edge_detect (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_line_n,
   output logic o_fall
);

   // ---------------------------------------------------------------
   // Falling edge seen only after a high level, then low held
   // ---------------------------------------------------------------
   logic [irq_ctrl_pkg::EXT_HOLD_CYCLES:0] hist_ff;
   logic [irq_ctrl_pkg::EXT_HOLD_CYCLES:0] nxt_hist;
   logic fall_ff;
   logic nxt_fall;

   always_comb begin
      nxt_hist = {hist_ff[irq_ctrl_pkg::EXT_HOLD_CYCLES-1:0], i_line_n};
      // High before, then low for the hold count
      nxt_fall = hist_ff[irq_ctrl_pkg::EXT_HOLD_CYCLES] &
                 ~(|nxt_hist[irq_ctrl_pkg::EXT_HOLD_CYCLES-1:0]);
      nxt_fall = nxt_fall & hist_ff[irq_ctrl_pkg::EXT_HOLD_CYCLES-1];
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         hist_ff <= '0;
         fall_ff <= 1'b0;
      end else begin
         hist_ff <= nxt_hist;
         fall_ff <= nxt_fall;
      end
   end

   assign o_fall = fall_ff;

endmodule
`default_nettype wire

// *** rtl/six_source_interrupt_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module six_source_interrupt_control (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [9:0] i_ram_addr,
   input wire logic [1:0] i_bit_pos,
   input wire logic i_bit_set,
   input wire logic i_bit_clr,
   input wire logic i_rd,
   input wire logic i_ext_irq_line_0_n,
   input wire logic i_ext_irq_line_1_n,
   input wire logic i_timer_a_ovf,
   input wire logic i_timer_b_ovf,
   input wire logic i_timer_c_ovf,
   input wire logic i_serial_eighth_shift,
   input wire logic i_serial_abort,
   input wire logic i_timer_b_ext_clk_sel,
   input wire logic i_return_from_irq_instr,
   output logic [3:0] o_rd_data,
   output logic o_bit_value,
   output logic o_irq_accept,
   output logic o_push_flags,
   output logic o_push_pc,
   output logic o_vector_jump,
   output logic [15:0] o_vector,
   output logic o_global_irq_enable,
   output logic o_timer_b_event
);

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // Bit instructions reach a flag only at its own location and bit
   function automatic logic bit_hit(input logic [9:0] addr, input logic [1:0] pos,
                                    input logic [1:0] loc, input logic [1:0] bpos);
      bit_hit = (addr == {8'h00, loc}) && (pos == bpos);
   endfunction

   logic in_range;
   assign in_range = (i_ram_addr >= irq_ctrl_pkg::LOC_CTRL_0) &&
                     (i_ram_addr <= irq_ctrl_pkg::LOC_CTRL_3);

   // ---------------------------------------------------------------
   // Event capture
   // ---------------------------------------------------------------
   logic ext0_fall;
   logic ext1_fall;
   logic [irq_ctrl_pkg::NUM_SRC-1:0] hw_set;

   // Each line passes an edge filter before it can raise its flag
   ext_edge_detect u_edge_ext0 (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_line_n(i_ext_irq_line_0_n),
      .o_fall(ext0_fall)
   );

   ext_edge_detect u_edge_ext1 (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_line_n(i_ext_irq_line_1_n),
      .o_fall(ext1_fall)
   );

   // Masked sources still latch their flag
   always_comb begin
      hw_set = '0;
      hw_set[irq_ctrl_pkg::SRC_EXT0] = ext0_fall;
      hw_set[irq_ctrl_pkg::SRC_EXT1] = ext1_fall;
      hw_set[irq_ctrl_pkg::SRC_TIMER_A] = i_timer_a_ovf;
      hw_set[irq_ctrl_pkg::SRC_TIMER_B] = i_timer_b_ovf;
      hw_set[irq_ctrl_pkg::SRC_TIMER_C] = i_timer_c_ovf;
      // Either a full eight-shift transfer or an abort raises the serial flag
      hw_set[irq_ctrl_pkg::SRC_SERIAL] = i_serial_eighth_shift | i_serial_abort;
   end

   // ---------------------------------------------------------------
   // Pending flags and masks
   // ---------------------------------------------------------------
   logic [irq_ctrl_pkg::NUM_SRC-1:0] pend_ff;
   logic [irq_ctrl_pkg::NUM_SRC-1:0] nxt_pend;
   logic [irq_ctrl_pkg::NUM_SRC-1:0] mask_ff;
   logic [irq_ctrl_pkg::NUM_SRC-1:0] nxt_mask;

   genvar g;
   generate
      for (g = 0; g < irq_ctrl_pkg::NUM_SRC; g++) begin : g_src
         logic sw_clr_pend;
         logic sw_set_mask;
         logic sw_clr_mask;
         always_comb begin
            sw_clr_pend = i_bit_clr && bit_hit(i_ram_addr, i_bit_pos,
                          irq_ctrl_pkg::SRC_LOC[g], irq_ctrl_pkg::PEND_BIT[g]);
            sw_set_mask = i_bit_set && bit_hit(i_ram_addr, i_bit_pos,
                          irq_ctrl_pkg::SRC_LOC[g], irq_ctrl_pkg::MASK_BIT[g]);
            sw_clr_mask = i_bit_clr && bit_hit(i_ram_addr, i_bit_pos,
                          irq_ctrl_pkg::SRC_LOC[g], irq_ctrl_pkg::MASK_BIT[g]);
            // Software set has no path into the flag; hardware set wins
            nxt_pend[g] = (pend_ff[g] & ~sw_clr_pend) | hw_set[g];
            // A set and a clear of one mask bit together leave it set
            nxt_mask[g] = sw_set_mask ? 1'b1 : (sw_clr_mask ? 1'b0 : mask_ff[g]);
         end
      end
   endgenerate

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         pend_ff <= irq_ctrl_pkg::PEND_RESET;
         mask_ff <= irq_ctrl_pkg::MASK_RESET;
      end else begin
         pend_ff <= nxt_pend;
         mask_ff <= nxt_mask;
      end
   end

   // ---------------------------------------------------------------
   // Priority select
   // ---------------------------------------------------------------
   logic [irq_ctrl_pkg::NUM_SRC-1:0] req;
   logic any_req;
   logic [15:0] win_vector;

   assign req = pend_ff & ~mask_ff;
   assign any_req = |req;

   always_comb begin
      win_vector = irq_ctrl_pkg::VEC_RESET;
      // Scan from the lowest priority up so the highest active source lands last
      for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            win_vector = irq_ctrl_pkg::VEC_TABLE[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // Entry sequence and global enable
   // ---------------------------------------------------------------
   irq_ctrl_pkg::entry_state_type state_ff;
   irq_ctrl_pkg::entry_state_type nxt_state;
   logic ie_ff;
   logic nxt_ie;
   logic [15:0] vector_ff;
   logic [15:0] nxt_vector;
   logic accept_ff;
   logic push_flags_ff;
   logic push_pc_ff;
   logic jump_ff;
   logic nxt_accept;
   logic nxt_push_flags;
   logic nxt_push_pc;
   logic nxt_jump;
   logic sw_set_ie;
   logic sw_clr_ie;

   always_comb begin
      nxt_state = state_ff;
      nxt_vector = vector_ff;
      case (state_ff)
         irq_ctrl_pkg::ST_IDLE: begin
            if (ie_ff && any_req) begin
               nxt_state = irq_ctrl_pkg::ST_FINISH;
               nxt_vector = win_vector;
            end
         end
         irq_ctrl_pkg::ST_FINISH: begin
            nxt_state = irq_ctrl_pkg::ST_CLEAR_PUSH;
         end
         irq_ctrl_pkg::ST_CLEAR_PUSH: begin
            nxt_state = irq_ctrl_pkg::ST_PUSH_JUMP;
         end
         irq_ctrl_pkg::ST_PUSH_JUMP: begin
            nxt_state = irq_ctrl_pkg::ST_IDLE;
         end
         default: begin
            nxt_state = irq_ctrl_pkg::ST_IDLE;
         end
      endcase
      nxt_accept = (nxt_state == irq_ctrl_pkg::ST_FINISH);
      // Flags go out in cycle two, the program counter over cycles two and three
      nxt_push_flags = (nxt_state == irq_ctrl_pkg::ST_CLEAR_PUSH);
      nxt_push_pc = (nxt_state == irq_ctrl_pkg::ST_CLEAR_PUSH) ||
                    (nxt_state == irq_ctrl_pkg::ST_PUSH_JUMP);
      nxt_jump = (nxt_state == irq_ctrl_pkg::ST_PUSH_JUMP);
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_ff <= irq_ctrl_pkg::ST_IDLE;
         vector_ff <= irq_ctrl_pkg::VEC_RESET;
         accept_ff <= 1'b0;
         push_flags_ff <= 1'b0;
         push_pc_ff <= 1'b0;
         jump_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         vector_ff <= nxt_vector;
         accept_ff <= nxt_accept;
         push_flags_ff <= nxt_push_flags;
         push_pc_ff <= nxt_push_pc;
         jump_ff <= nxt_jump;
      end
   end

   // ---------------------------------------------------------------
   // Global enable
   // ---------------------------------------------------------------
   always_comb begin
      sw_set_ie = i_bit_set && bit_hit(i_ram_addr, i_bit_pos, irq_ctrl_pkg::IE_LOC,
                                       irq_ctrl_pkg::IE_BIT);
      sw_clr_ie = i_bit_clr && bit_hit(i_ram_addr, i_bit_pos, irq_ctrl_pkg::IE_LOC,
                                       irq_ctrl_pkg::IE_BIT);
      // Entry clear beats a return or software set in the same cycle
      if (nxt_state == irq_ctrl_pkg::ST_CLEAR_PUSH) begin
         nxt_ie = 1'b0;
      end else if (i_return_from_irq_instr || sw_set_ie) begin
         nxt_ie = 1'b1;
      end else if (sw_clr_ie) begin
         nxt_ie = 1'b0;
      end else begin
         nxt_ie = ie_ff;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         ie_ff <= irq_ctrl_pkg::IE_RESET;
      end else begin
         ie_ff <= nxt_ie;
      end
   end

   // ---------------------------------------------------------------
   // Register read-back
   // ---------------------------------------------------------------
   logic [3:0] rd_data_ff;
   logic [3:0] nxt_rd_data;
   logic bit_value_ff;
   logic nxt_bit_value;
   logic [3:0] word_q;

   always_comb begin
      // Reserved bits and addresses outside the block read as zero
      word_q = 4'h0;
      if (i_ram_addr[1:0] == irq_ctrl_pkg::IE_LOC) begin
         word_q[irq_ctrl_pkg::IE_BIT] = ie_ff;
      end
      for (int i = 0; i < irq_ctrl_pkg::NUM_SRC; i++) begin
         if (i_ram_addr[1:0] == irq_ctrl_pkg::SRC_LOC[i]) begin
            word_q[irq_ctrl_pkg::PEND_BIT[i]] = pend_ff[i];
            word_q[irq_ctrl_pkg::MASK_BIT[i]] = mask_ff[i];
         end
      end
      if (!in_range) begin
         word_q = 4'h0;
      end
      nxt_rd_data = i_rd ? word_q : rd_data_ff;
      nxt_bit_value = word_q[i_bit_pos];
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rd_data_ff <= 4'h0;
         bit_value_ff <= 1'b0;
      end else begin
         rd_data_ff <= nxt_rd_data;
         bit_value_ff <= nxt_bit_value;
      end
   end

   // ---------------------------------------------------------------
   // Timer B event clock
   // ---------------------------------------------------------------
   logic tb_event_ff;
   logic nxt_tb_event;

   always_comb begin
      // Ext1 edges count even while its request is masked
      nxt_tb_event = i_timer_b_ext_clk_sel & ext1_fall;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         tb_event_ff <= 1'b0;
      end else begin
         tb_event_ff <= nxt_tb_event;
      end
   end

   assign o_rd_data = rd_data_ff;
   assign o_bit_value = bit_value_ff;
   assign o_irq_accept = accept_ff;
   assign o_push_flags = push_flags_ff;
   assign o_push_pc = push_pc_ff;
   assign o_vector_jump = jump_ff;
   assign o_vector = vector_ff;
   assign o_global_irq_enable = ie_ff;
   assign o_timer_b_event = tb_event_ff;

endmodule
`default_nettype wire

// *** bench/irq_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Peripheral side: external lines and event pulses
// ---------------------------------------------------------------
module irq_source_model (
   input wire logic i_core_clk,
   output logic [1:0] o_ext_n,
   output logic [4:0] o_pulse
);
   initial begin
      o_ext_n = 2'h3;
      o_pulse = 5'h00;
   end
   // Lines stay low four cycles and high three, beyond the edge filter
   task automatic fall(input int n);
      @(negedge i_core_clk);
      o_ext_n[n] = 1'b0;
      repeat (4) @(negedge i_core_clk);
      o_ext_n[n] = 1'b1;
      repeat (3) @(negedge i_core_clk);
   endtask
   // Index 0..2 timers A..C, 3 eighth shift, 4 abort
   task automatic pulse(input int n);
      @(negedge i_core_clk);
      o_pulse[n] = 1'b1;
      @(negedge i_core_clk);
      o_pulse[n] = 1'b0;
   endtask
endmodule
`default_nettype wire

// *** bench/irq_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_checker (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [9:0] i_ram_addr,
   input wire logic i_rd,
   input wire logic i_return_from_irq_instr,
   input wire logic [3:0] o_rd_data,
   input wire logic o_irq_accept,
   input wire logic o_push_flags,
   input wire logic o_push_pc,
   input wire logic o_vector_jump,
   input wire logic [15:0] o_vector,
   input wire logic o_global_irq_enable
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);
   a_accept_needs_enable: assert property (o_irq_accept |-> $past(o_global_irq_enable))
      else $error("accept without global enable");
   a_entry_clears_enable: assert property (
      o_irq_accept |=> o_push_flags && !o_global_irq_enable)
      else $error("enable not cleared on entry");
   a_push_pc_two: assert property (o_irq_accept |=> o_push_pc [*2] ##1 !o_push_pc)
      else $error("pc push not two cycles");
   a_jump_third: assert property (o_irq_accept |-> ##2 o_vector_jump)
      else $error("jump not in third cycle");
   a_no_reentry: assert property (o_irq_accept |=> !o_irq_accept [*3])
      else $error("entry restarted during sequence");
   a_return_sets_enable: assert property (
      i_return_from_irq_instr && !o_irq_accept |=> o_global_irq_enable)
      else $error("return did not set enable");
   a_vector_legal: assert property (
      o_irq_accept |-> o_vector inside {16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A,
                                        16'h000C})
      else $error("illegal vector");
   a_vector_on_accept: assert property ($changed(o_vector) |-> o_irq_accept)
      else $error("vector moved without accept");
   a_unmapped_read: assert property (i_rd && i_ram_addr > 10'h003 |=> o_rd_data == 4'h0)
      else $error("unmapped read not zero");
endmodule
bind six_source_interrupt_control irq_ctrl_checker irq_ctrl_checker_i (
   .i_core_clk, .i_rst_n, .i_ram_addr, .i_rd, .i_return_from_irq_instr, .o_rd_data,
   .o_irq_accept, .o_push_flags, .o_push_pc, .o_vector_jump, .o_vector, .o_global_irq_enable);
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] addr = 10'h000;
   logic [1:0] pos = 2'h0;
   logic bset = 1'b0;
   logic bclr = 1'b0;
   logic rd = 1'b0;
   logic sel = 1'b0;
   logic ret = 1'b0;
   logic [1:0] ext_n;
   logic [4:0] pul;
   logic [3:0] rdat;
   logic bv, acc, pf, ppc, jmp, gie, tbe;
   logic [15:0] vec;
   int failures = 0;
   int total_checks = 0;
   int n_acc = 0;
   int n_tbe = 0;
   always #4 clk = ~clk;
   always @(posedge clk) begin
      if (acc === 1'b1) n_acc++;
      if (tbe === 1'b1) n_tbe++;
   end
   irq_source_model irq_source_model_i (.i_core_clk(clk), .o_ext_n(ext_n), .o_pulse(pul));
   six_source_interrupt_control six_source_interrupt_control_i (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_ram_addr(addr), .i_bit_pos(pos), .i_bit_set(bset),
      .i_bit_clr(bclr), .i_rd(rd), .i_ext_irq_line_0_n(ext_n[0]), .i_ext_irq_line_1_n(ext_n[1]),
      .i_timer_a_ovf(pul[0]), .i_timer_b_ovf(pul[1]), .i_timer_c_ovf(pul[2]),
      .i_serial_eighth_shift(pul[3]), .i_serial_abort(pul[4]), .i_timer_b_ext_clk_sel(sel),
      .i_return_from_irq_instr(ret), .o_rd_data(rdat), .o_bit_value(bv), .o_irq_accept(acc),
      .o_push_flags(pf), .o_push_pc(ppc), .o_vector_jump(jmp), .o_vector(vec),
      .o_global_irq_enable(gie), .o_timer_b_event(tbe));
   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [1:0] loc, input logic [1:0] p, input logic s);
      @(negedge clk);
      addr = {8'h00, loc};
      pos = p;
      bset = s;
      bclr = ~s;
      @(negedge clk);
      bset = 1'b0;
      bclr = 1'b0;
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [3:0] exp);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk({12'h000, rdat}, {12'h000, exp});
   endtask
   task automatic bit_chk(input logic [1:0] loc, input logic [1:0] p, input logic exp);
      @(negedge clk);
      addr = {8'h00, loc};
      pos = p;
      @(negedge clk);
      chk({15'h0000, bv}, {15'h0000, exp});
   endtask
   task automatic give_ret();
      @(negedge clk);
      ret = 1'b1;
      @(negedge clk);
      ret = 1'b0;
   endtask
   task automatic enter(input logic [15:0] exp_vec);
      int k;
      give_ret();
      k = 0;
      while (acc !== 1'b1 && k < 10) begin
         @(negedge clk);
         k++;
      end
      chk({15'h0000, acc}, 16'h0001);
      chk(vec, exp_vec);
      @(negedge clk);
      chk({14'h0000, pf, gie}, 16'h0002);
      @(negedge clk);
      chk({14'h0000, ppc, jmp}, 16'h0003);
   endtask
   task automatic fire(input int s);
      if (s < 2) irq_source_model_i.fall(s);
      else if (s < 5) irq_source_model_i.pulse(s - 2);
      else irq_source_model_i.pulse(3);
   endtask
   task automatic end_of_test();
      if (failures == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #50000;
      failures++;
      end_of_test();
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      logic [1:0] l, pb, mb;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      rd_chk(10'h000, 4'h8);
      rd_chk(10'h001, 4'hA);
      rd_chk(10'h002, 4'hA);
      rd_chk(10'h003, 4'h2);
      rd_chk(10'h004, 4'h0);
      chk(vec, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         l = irq_ctrl_pkg::SRC_LOC[i];
         pb = irq_ctrl_pkg::PEND_BIT[i];
         mb = irq_ctrl_pkg::MASK_BIT[i];
         op(l, pb, 1'b1);
         bit_chk(l, pb, 1'b0);
         op(l, mb, 1'b0);
         fire(i);
         bit_chk(l, pb, 1'b1);
         chk(16'(n_acc), 16'(i));
         enter(16'h0002 + 16'(2 * i));
         op(l, pb, 1'b0);
         bit_chk(l, pb, 1'b0);
         op(l, mb, 1'b1);
      end
      // Several pending at once
      for (int i = 2; i < 6; i++) op(irq_ctrl_pkg::SRC_LOC[i], irq_ctrl_pkg::MASK_BIT[i], 1'b0);
      fire(4);
      fire(2);
      fire(5);
      enter(16'h0006);
      op(2'h1, 2'h2, 1'b0);
      enter(16'h000A);
      op(2'h2, 2'h2, 1'b0);
      enter(16'h000C);
      op(2'h3, 2'h0, 1'b0);
      for (int i = 2; i < 6; i++) op(irq_ctrl_pkg::SRC_LOC[i], irq_ctrl_pkg::MASK_BIT[i], 1'b1);
      // Masked events latch but are not taken while enabled
      give_ret();
      bit_chk(2'h0, 2'h0, 1'b1);
      fire(3);
      irq_source_model_i.pulse(4);
      repeat (4) @(negedge clk);
      chk(16'(n_acc), 16'd9);
      bit_chk(2'h2, 2'h0, 1'b1);
      bit_chk(2'h3, 2'h0, 1'b1);
      fork
         op(2'h2, 2'h0, 1'b0);
         irq_source_model_i.pulse(1);
      join
      bit_chk(2'h2, 2'h0, 1'b1);
      op(2'h2, 2'h0, 1'b0);
      sel = 1'b1;
      fire(1);
      chk(16'(n_tbe), 16'd1);
      chk(16'(n_acc), 16'd9);
      op(2'h0, 2'h0, 1'b0);
      bit_chk(2'h0, 2'h0, 1'b0);
      op(2'h0, 2'h0, 1'b1);
      bit_chk(2'h0, 2'h0, 1'b1);
      @(negedge clk);
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      rd_chk(10'h000, 4'h8);
      rd_chk(10'h001, 4'hA);
      chk(vec, 16'h0000);
      end_of_test();
   end
endmodule
`default_nettype wire
